/* hdl/pidm_monitor.sv */
/*
  Process supervision around the PID controller: feedback-low message with
  hysteresis, deviation alarm, PID disable input, output clamp, display
  scaling, output routing, interrupt status and a plain register port.
  Assumes all inputs are synchronous to mclk and the PID arithmetic is
  outside; the raw PID output arrives on pid_raw_out.
*/
`timescale 1ns/10ps
`default_nettype none
module pidm_monitor
  import pidm_pkg::*;
#(
  parameter int NUM_DOUT = 3,
  parameter int NUM_DIN = 6
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [PIDM_AW-1:0] reg_addr,
  input wire logic [PIDM_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [PIDM_DW-1:0] reg_rdata,
  input wire logic run_mode,
  input wire logic [15:0] setpoint,
  input wire logic [15:0] process_value,
  input wire logic [15:0] pid_raw_out,
  input wire logic [NUM_DIN-1:0] digital_in,
  output logic feedback_low_flag,
  output logic deviation_alarm,
  output logic pid_active,
  output logic pid_bypass,
  output logic [15:0] pid_out_limited,
  output logic [NUM_DOUT-1:0] digital_out,
  output logic [24:0] setpoint_monitor,
  output logic [24:0] process_value_monitor,
  output logic irq
);

  // Elaboration checks: up to four selector fields fit, input six must exist
  if (NUM_DOUT < 1 || NUM_DOUT > 4) begin : g_bad_dout
    $error("NUM_DOUT must be 1 to 4");
  end
  if (NUM_DIN < 6) begin : g_bad_din
    $error("NUM_DIN must be at least 6");
  end

  typedef struct packed {
    logic pid_en;
    logic [2:0] din_sel;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] maxdev;
    logic [8:0] sp_scale;
    logic [8:0] pv_scale;
    logic [15:0] out_lim;
    logic [NUM_DOUT-1:0][4:0] fsel;
    pidm_fb_t fb;
    logic dev;
    logic act;
    logic [1:0] sts;
    logic [1:0] ien;
    logic [NUM_DOUT-1:0] dout;
    logic [15:0] pid_out;
    logic [24:0] sp_mon;
    logic [24:0] pv_mon;
    logic [PIDM_DW-1:0] rdata;
  } pidm_state_t;

  pidm_state_t st_q;
  pidm_state_t st_d;
  logic [NUM_DOUT-1:0] dout_c;
  logic dis_in;
  logic act_c;
  logic signed [16:0] dev_err;
  logic [16:0] dev_mag;

  // Values beyond the accepted range are pulled to the nearest edge
  function automatic logic [15:0] pidm_pct(input logic [15:0] v);
    pidm_pct = (v > PIDM_PCT_MAX) ? PIDM_PCT_MAX : v;
  endfunction

  function automatic logic [8:0] pidm_scale(input logic [15:0] v);
    if (v < {7'h00, PIDM_SCALE_MIN}) begin
      pidm_scale = PIDM_SCALE_MIN;
    end else if (v > {7'h00, PIDM_SCALE_MAX}) begin
      pidm_scale = PIDM_SCALE_MAX;
    end else begin
      pidm_scale = v[8:0];
    end
  endfunction

  function automatic logic [2:0] pidm_sel(input logic [2:0] v);
    if (v < PIDM_SEL_MIN) begin
      pidm_sel = PIDM_SEL_MIN;
    end else if (v > PIDM_SEL_MAX) begin
      pidm_sel = PIDM_SEL_MAX;
    end else begin
      pidm_sel = v;
    end
  endfunction

  // The selected terminal disables PID only while PID is in use
  assign dis_in = digital_in[st_q.din_sel - PIDM_SEL_MIN];
  assign act_c = st_q.pid_en & ~dis_in;

  // Signed error, judged by its size so both directions raise the alarm
  assign dev_err = signed'({1'b0, setpoint}) - signed'({1'b0, process_value});
  assign dev_mag = dev_err[16] ? 17'(-dev_err) : 17'(dev_err);

  // One selector per digital output or relay
  for (genvar i = 0; i < NUM_DOUT; i++) begin : g_dout
    pidm_out_sel u_sel (
      .func_sel(st_q.fsel[i]),
      .fb_low(st_q.fb == PIDM_FB_LOW),
      .dev_alarm(st_q.dev),
      .pin_out(dout_c[i])
    );
  end

  // Next state: supervision, register writes, status and read data
  always_comb begin
    st_d = st_q;
    st_d.act = act_c;
    st_d.dout = dout_c;

    // Feedback-low hysteresis; the set wins if limits are crossed over
    case (st_q.fb)
      PIDM_FB_CLEAR: begin
        if (run_mode && process_value < st_q.lower) begin
          st_d.fb = PIDM_FB_LOW;
        end
      end
      PIDM_FB_LOW: begin
        if (!run_mode) begin
          st_d.fb = PIDM_FB_CLEAR;
        end else if (process_value < st_q.lower) begin
          st_d.fb = PIDM_FB_LOW;
        end else if (process_value > st_q.upper) begin
          st_d.fb = PIDM_FB_CLEAR;
        end
      end
      default: st_d.fb = PIDM_FB_CLEAR;
    endcase
    // The flag feeds only status and outputs; no trip path exists

    // Deviation alarm follows the error while PID control is active
    st_d.dev = act_c && (dev_mag > {1'b0, st_q.maxdev});

    // Clamp toward the limit; when bypassed the drive uses its own frequency
    st_d.pid_out = (pid_raw_out > st_q.out_lim) ? st_q.out_lim : pid_raw_out;

    // Display products only, never fed back into control
    st_d.sp_mon = {9'h000, setpoint} * {16'h0000, st_q.sp_scale};
    st_d.pv_mon = {9'h000, process_value} * {16'h0000, st_q.pv_scale};

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        PIDM_CTRL_OFS: begin
          st_d.pid_en = reg_wdata[PIDM_CTRL_EN_BIT];
          st_d.din_sel = pidm_sel(reg_wdata[PIDM_CTRL_SEL_LSB +: 3]);
        end
        PIDM_UPPER_OFS: st_d.upper = pidm_pct(reg_wdata[15:0]);
        PIDM_LOWER_OFS: st_d.lower = pidm_pct(reg_wdata[15:0]);
        PIDM_MAXDEV_OFS: st_d.maxdev = pidm_pct(reg_wdata[15:0]);
        PIDM_SPSCALE_OFS: st_d.sp_scale = pidm_scale(reg_wdata[15:0]);
        PIDM_PVSCALE_OFS: st_d.pv_scale = pidm_scale(reg_wdata[15:0]);
        PIDM_OUTLIM_OFS: st_d.out_lim = pidm_pct(reg_wdata[15:0]);
        PIDM_OUTFN_OFS: begin
          for (int i = 0; i < NUM_DOUT; i++) begin
            st_d.fsel[i] = reg_wdata[i*PIDM_OUTFN_STRIDE +: 5];
          end
        end
        PIDM_IEN_OFS: st_d.ien = reg_wdata[1:0];
        default: st_d.ien = st_q.ien;
      endcase
    end

    // Sticky events on rising flags; a new event beats a clear
    st_d.sts = st_q.sts;
    if (reg_wr && reg_addr == PIDM_CLR_OFS) begin
      st_d.sts = st_q.sts & ~reg_wdata[1:0];
    end
    if (st_d.fb == PIDM_FB_LOW && st_q.fb == PIDM_FB_CLEAR) begin
      st_d.sts[PIDM_STS_FB_BIT] = 1'b1;
    end
    if (st_d.dev && !st_q.dev) begin
      st_d.sts[PIDM_STS_DEV_BIT] = 1'b1;
    end

    // Read data stand for the one cycle after the strobe
    st_d.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        PIDM_CTRL_OFS: begin
          st_d.rdata[PIDM_CTRL_EN_BIT] = st_q.pid_en;
          st_d.rdata[PIDM_CTRL_SEL_LSB +: 3] = st_q.din_sel;
        end
        PIDM_UPPER_OFS: st_d.rdata[15:0] = st_q.upper;
        PIDM_LOWER_OFS: st_d.rdata[15:0] = st_q.lower;
        PIDM_MAXDEV_OFS: st_d.rdata[15:0] = st_q.maxdev;
        PIDM_SPSCALE_OFS: st_d.rdata[8:0] = st_q.sp_scale;
        PIDM_PVSCALE_OFS: st_d.rdata[8:0] = st_q.pv_scale;
        PIDM_OUTLIM_OFS: st_d.rdata[15:0] = st_q.out_lim;
        PIDM_OUTFN_OFS: begin
          for (int i = 0; i < NUM_DOUT; i++) begin
            st_d.rdata[i*PIDM_OUTFN_STRIDE +: 5] = st_q.fsel[i];
          end
        end
        PIDM_STS_OFS: st_d.rdata[1:0] = st_q.sts;
        PIDM_IEN_OFS: st_d.rdata[1:0] = st_q.ien;
        PIDM_LIVE_OFS: begin
          st_d.rdata[PIDM_STS_FB_BIT] = (st_q.fb == PIDM_FB_LOW);
          st_d.rdata[PIDM_STS_DEV_BIT] = st_q.dev;
          st_d.rdata[PIDM_LIVE_ACT_BIT] = st_q.act;
          st_d.rdata[PIDM_LIVE_RUN_BIT] = run_mode;
        end
        PIDM_SPMON_OFS: st_d.rdata[24:0] = st_q.sp_mon;
        PIDM_PVMON_OFS: st_d.rdata[24:0] = st_q.pv_mon;
        default: st_d.rdata = '0;
      endcase
    end
  end

  // State register; ce low freezes everything, bus included
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
      st_q.pid_en <= PIDM_EN_RST;
      st_q.din_sel <= PIDM_SEL_RST;
      st_q.upper <= PIDM_UPPER_RST;
      st_q.lower <= PIDM_LOWER_RST;
      st_q.maxdev <= PIDM_MAXDEV_RST;
      st_q.sp_scale <= PIDM_SCALE_RST;
      st_q.pv_scale <= PIDM_SCALE_RST;
      st_q.out_lim <= PIDM_OUTLIM_RST;
      st_q.fb <= PIDM_FB_CLEAR;
      st_q.dev <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata = st_q.rdata;
  assign feedback_low_flag = (st_q.fb == PIDM_FB_LOW);
  assign deviation_alarm = st_q.dev;
  assign pid_active = st_q.act;
  assign pid_bypass = ~st_q.act;
  assign pid_out_limited = st_q.pid_out;
  assign digital_out = st_q.dout;
  assign setpoint_monitor = st_q.sp_mon;
  assign process_value_monitor = st_q.pv_mon;
  assign irq = |(st_q.sts & st_q.ien);

  // Checks on the supervision behaviour
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence fb_rise_s;
    !feedback_low_flag ##1 feedback_low_flag;
  endsequence

  sequence dev_rise_s;
    !deviation_alarm ##1 deviation_alarm;
  endsequence

  fb_set_low_a: assert property (
    ce && run_mode && process_value < st_q.lower |=> feedback_low_flag)
    else $error("feedback low not set below lower limit");

  fb_clear_up_a: assert property (
    ce && run_mode && process_value > st_q.upper && !(process_value < st_q.lower)
    |=> !feedback_low_flag)
    else $error("feedback low not cleared above upper limit");

  fb_hold_band_a: assert property (
    ce && feedback_low_flag && run_mode && !(process_value > st_q.upper)
    |=> feedback_low_flag)
    else $error("feedback low dropped inside the band");

  fb_stop_clr_a: assert property (
    ce && !run_mode |=> !feedback_low_flag)
    else $error("feedback low survived stop");

  fb_rise_run_a: assert property (
    fb_rise_s |-> $past(run_mode) && $past(ce))
    else $error("feedback low rose outside run");

  dev_alarm_val_a: assert property (
    ce |=> deviation_alarm == $past(st_q.pid_en && !dis_in &&
      ((setpoint > process_value) ? (setpoint - process_value) > st_q.maxdev
                                  : (process_value - setpoint) > st_q.maxdev)))
    else $error("deviation alarm wrong");

  dev_needs_pid_a: assert property (
    dev_rise_s |-> $past(st_q.pid_en))
    else $error("deviation alarm without pid enabled");

  maxdev_range_a: assert property (
    st_q.maxdev <= PIDM_PCT_MAX)
    else $error("deviation limit out of range");

  out_clamp_a: assert property (
    ce ##1 1'b1 |-> pid_out_limited <= $past(st_q.out_lim))
    else $error("pid output above limit");

  route_fb_a: assert property (
    ce && st_q.fsel[0] == PIDM_FN_FBLOW |=> digital_out[0] == $past(feedback_low_flag))
    else $error("code 25 output mismatch");

  route_dev_a: assert property (
    ce && st_q.fsel[0] == PIDM_FN_DEV |=> digital_out[0] == $past(deviation_alarm))
    else $error("code 12 output mismatch");

  disable_input_a: assert property (
    ce && st_q.pid_en && dis_in |=> !pid_active && pid_bypass)
    else $error("disable input ignored");

  sel_range_a: assert property (
    st_q.din_sel >= PIDM_SEL_MIN && st_q.din_sel <= PIDM_SEL_MAX)
    else $error("disable input select out of range");

  sticky_fb_a: assert property (
    fb_rise_s |-> st_q.sts[PIDM_STS_FB_BIT])
    else $error("feedback low event not latched");

endmodule
`default_nettype wire

/* hdl/pidm_out_sel.sv */
/*
  Function selector for one digital output or relay.
  Assumes flags are registered by the caller; the output is combinational.
*/
`timescale 1ns/10ps
`default_nettype none
module pidm_out_sel
  import pidm_pkg::*;
(
  input wire logic [4:0] func_sel,
  input wire logic fb_low,
  input wire logic dev_alarm,
  output logic pin_out
);

  // Unknown codes leave the output off; other functions live elsewhere
  always_comb begin
    case (func_sel)
      PIDM_FN_FBLOW: pin_out = fb_low;
      PIDM_FN_DEV: pin_out = dev_alarm;
      default: pin_out = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

/* hdl/pidm_pkg.sv */
/*
  Constants for the process supervision block around the PID controller:
  register offsets, field positions, reset values, value ranges and the
  output function codes.
  Assumes percent values in units of 0.01 % and scale factors in units of 0.1.
*/
package pidm_pkg;

  // Register bus geometry
  localparam int PIDM_AW = 8;
  localparam int PIDM_DW = 32;

  // Register byte offsets
  localparam logic [7:0] PIDM_CTRL_OFS = 8'h00;
  localparam logic [7:0] PIDM_UPPER_OFS = 8'h04;
  localparam logic [7:0] PIDM_LOWER_OFS = 8'h08;
  localparam logic [7:0] PIDM_MAXDEV_OFS = 8'h0c;
  localparam logic [7:0] PIDM_SPSCALE_OFS = 8'h10;
  localparam logic [7:0] PIDM_PVSCALE_OFS = 8'h14;
  localparam logic [7:0] PIDM_OUTLIM_OFS = 8'h18;
  localparam logic [7:0] PIDM_OUTFN_OFS = 8'h1c;
  localparam logic [7:0] PIDM_STS_OFS = 8'h20;
  localparam logic [7:0] PIDM_CLR_OFS = 8'h24;
  localparam logic [7:0] PIDM_IEN_OFS = 8'h28;
  localparam logic [7:0] PIDM_LIVE_OFS = 8'h2c;
  localparam logic [7:0] PIDM_SPMON_OFS = 8'h30;
  localparam logic [7:0] PIDM_PVMON_OFS = 8'h34;

  // Field positions
  localparam int PIDM_CTRL_EN_BIT = 0;
  localparam int PIDM_CTRL_SEL_LSB = 4;
  localparam int PIDM_OUTFN_STRIDE = 8;
  localparam int PIDM_STS_FB_BIT = 0;
  localparam int PIDM_STS_DEV_BIT = 1;
  localparam int PIDM_LIVE_ACT_BIT = 2;
  localparam int PIDM_LIVE_RUN_BIT = 3;

  // Reset values
  localparam logic PIDM_EN_RST = 1'b0;
  localparam logic [2:0] PIDM_SEL_RST = 3'h6;
  localparam logic [15:0] PIDM_UPPER_RST = 16'h0000;
  localparam logic [15:0] PIDM_LOWER_RST = 16'h0000;
  localparam logic [15:0] PIDM_MAXDEV_RST = 16'h012c;
  localparam logic [8:0] PIDM_SCALE_RST = 9'h00a;
  localparam logic [15:0] PIDM_OUTLIM_RST = 16'h2710;
  localparam logic [4:0] PIDM_FN_RST = 5'h00;

  // Accepted ranges
  localparam logic [15:0] PIDM_PCT_MAX = 16'h2710;
  localparam logic [8:0] PIDM_SCALE_MIN = 9'h001;
  localparam logic [8:0] PIDM_SCALE_MAX = 9'h147;
  localparam logic [2:0] PIDM_SEL_MIN = 3'h1;
  localparam logic [2:0] PIDM_SEL_MAX = 3'h6;

  // Output function codes
  localparam logic [4:0] PIDM_FN_DEV = 5'h0c;
  localparam logic [4:0] PIDM_FN_FBLOW = 5'h19;

  // Feedback-low supervision states
  typedef enum logic {
    PIDM_FB_CLEAR = 1'b0,
    PIDM_FB_LOW = 1'b1
  } pidm_fb_t;

endpackage

/* tb/pid_process_monitor_tb_top.sv */
/*
  Self-checking bench for the process supervision block.
  Assumes the register port answers reads one cycle later and never stalls.
*/
`timescale 1ns/10ps
`default_nettype none
module pid_process_monitor_tb_top
  import pidm_pkg::*;
;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic run_mode = 1'b0;
  logic [15:0] setpoint = 16'h0;
  logic [15:0] process_value = 16'h0;
  logic [15:0] pid_raw_out = 16'h0;
  logic dis_req = 1'b0;
  logic [2:0] dis_pin = 3'h6;
  logic [5:0] digital_in;
  logic [31:0] reg_rdata;
  logic feedback_low_flag, deviation_alarm, pid_active, pid_bypass, irq;
  logic [15:0] pid_out_limited;
  logic [2:0] digital_out;
  logic [24:0] setpoint_monitor, process_value_monitor;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  int seed = 48136;
  logic [31:0] expq[$];
  logic rd_seen = 1'b0;
  logic [15:0] r;
  logic [15:0] pv_tab [7] = '{16'h07d0, 16'h07cf, 16'h1388, 16'h1389, 16'h03e8, 16'h03e8, 16'h03e8};
  logic run_tab [7] = '{1, 1, 1, 1, 1, 0, 0};
  logic flag_tab [7] = '{0, 1, 1, 0, 1, 0, 0};

  always #2.5 mclk = ~mclk;

  pidm_monitor dut (.mclk(mclk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .run_mode(run_mode), .setpoint(setpoint), .process_value(process_value),
    .pid_raw_out(pid_raw_out), .digital_in(digital_in),
    .feedback_low_flag(feedback_low_flag), .deviation_alarm(deviation_alarm),
    .pid_active(pid_active), .pid_bypass(pid_bypass), .pid_out_limited(pid_out_limited),
    .digital_out(digital_out), .setpoint_monitor(setpoint_monitor),
    .process_value_monitor(process_value_monitor), .irq(irq));

  pidm_plant plant (.mclk(mclk), .sys_rst(sys_rst), .run_mode(run_mode),
    .disable_req(dis_req), .disable_pin(dis_pin), .digital_in(digital_in));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One-cycle strobes; a clock edge always passes before the next one
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    expq.push_back(exp);
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, zero otherwise
  always @(posedge mclk) begin
    if (rd_seen) begin
      check(reg_rdata, expq.pop_front());
    end else if (!sys_rst && reg_rdata !== 32'h0) begin
      check(reg_rdata, 32'h0);
    end
    rd_seen <= reg_rd;
  end

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    // Reset values, clamping and refused places
    rd(PIDM_CTRL_OFS, 32'h60);
    rd(PIDM_MAXDEV_OFS, 32'h12c);
    rd(PIDM_SPSCALE_OFS, 32'ha);
    rd(PIDM_PVSCALE_OFS, 32'ha);
    rd(PIDM_OUTLIM_OFS, 32'h2710);
    rd(PIDM_OUTFN_OFS, 32'h0);
    rd(8'h3c, 32'h0);
    rd(PIDM_CLR_OFS, 32'h0);
    wr(PIDM_MAXDEV_OFS, 32'hffff);
    rd(PIDM_MAXDEV_OFS, 32'h2710);
    wr(PIDM_MAXDEV_OFS, 32'h12c);
    wr(PIDM_CTRL_OFS, 32'h71);
    rd(PIDM_CTRL_OFS, 32'h61);
    wr(PIDM_CTRL_OFS, 32'h60);
    // Hysteresis walk: strict bounds, hold, stop clears, set only in run
    wr(PIDM_UPPER_OFS, 32'h1388);
    wr(PIDM_LOWER_OFS, 32'h07d0);
    wr(PIDM_OUTFN_OFS, 32'h0c19);
    rd(PIDM_UPPER_OFS, 32'h1388);
    rd(PIDM_LOWER_OFS, 32'h7d0);
    rd(PIDM_OUTFN_OFS, 32'hc19);
    for (int i = 0; i < 7; i++) begin
      @(posedge mclk);
      process_value <= pv_tab[i];
      run_mode <= run_tab[i];
      settle(3);
      check(feedback_low_flag, flag_tab[i]);
      check(digital_out[0], flag_tab[i]);
      check(deviation_alarm, 1'b0);
    end
    // Sticky status and the level interrupt
    rd(PIDM_STS_OFS, 32'h1);
    check(irq, 1'b0);
    wr(PIDM_IEN_OFS, 32'h3);
    rd(PIDM_IEN_OFS, 32'h3);
    settle(1);
    check(irq, 1'b1);
    wr(PIDM_CLR_OFS, 32'h3);
    settle(1);
    check(irq, 1'b0);
    rd(PIDM_STS_OFS, 32'h0);
    // Deviation in both directions, strict limit
    wr(PIDM_CTRL_OFS, 32'h61);
    setpoint <= 16'h1388;
    process_value <= 16'h14b5;
    settle(3);
    check(deviation_alarm, 1'b1);
    check(digital_out[1], 1'b1);
    check(setpoint_monitor, 32'd50000);
    @(posedge mclk);
    process_value <= 16'h14b4;
    settle(3);
    check(deviation_alarm, 1'b0);
    check(digital_out[1], 1'b0);
    @(posedge mclk);
    process_value <= 16'h125b;
    settle(3);
    check(deviation_alarm, 1'b1);
    // Clock enable low freezes the deviation alarm and the value display against a changed input
    @(posedge mclk);
    ce <= 1'b0;
    process_value <= 16'h1388;
    settle(3);
    check(deviation_alarm, 1'b1);
    check(process_value_monitor, 32'd46990);
    @(posedge mclk);
    ce <= 1'b1;
    settle(2);
    check(deviation_alarm, 1'b0);
    check(process_value_monitor, 32'd50000);
    @(posedge mclk);
    process_value <= 16'h125b;
    // Disable input on the reset pin, then on input 1
    dis_req <= 1'b1;
    settle(4);
    check(pid_bypass, 1'b1);
    check(deviation_alarm, 1'b0);
    rd(PIDM_LIVE_OFS, 32'h0);
    wr(PIDM_CTRL_OFS, 32'h11);
    dis_pin <= 3'h1;
    settle(4);
    check(pid_active, 1'b0);
    wr(PIDM_CTRL_OFS, 32'h10);
    dis_req <= 1'b0;
    settle(4);
    check(pid_bypass, 1'b1);
    check(deviation_alarm, 1'b0);
    wr(PIDM_CTRL_OFS, 32'h11);
    settle(3);
    rd(PIDM_LIVE_OFS, 32'h6);
    // Output clamp and display scaling with random values
    wr(PIDM_OUTLIM_OFS, 32'h1388);
    wr(PIDM_SPSCALE_OFS, 32'h147);
    wr(PIDM_PVSCALE_OFS, 32'h0);
    rd(PIDM_PVSCALE_OFS, 32'h1);
    for (int i = 0; i < 20; i++) begin
      r = 16'($random(seed));
      @(posedge mclk);
      pid_raw_out <= r;
      setpoint <= ~r;
      process_value <= {r[7:0], r[15:8]};
      settle(2);
      check(pid_out_limited, (r > 16'h1388) ? 16'h1388 : r);
      check(setpoint_monitor, {16'h0, ~r} * 32'd327);
      check(process_value_monitor, {16'h0, r[7:0], r[15:8]});
    end
    rd(PIDM_SPMON_OFS, {16'h0, ~r} * 32'd327);
    rd(PIDM_PVMON_OFS, {16'h0, r[7:0], r[15:8]});
    settle(3);
    finish_test();
  end
endmodule
`default_nettype wire

/* tb/pidm_plant.sv */
/*
  Plant side model: the operator's wiring on the digital inputs.
  Assumes one clock, and that the bench says which input carries the disable function.
*/
`timescale 1ns/10ps
`default_nettype none
module pidm_plant
  import pidm_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic run_mode,
  input wire logic disable_req,
  input wire logic [2:0] disable_pin,
  output logic [5:0] digital_in
);
  logic held_q;
  logic [5:0] noise_q;

  // The operator flips the disable switch only while the drive stands still
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      held_q <= 1'b0;
      noise_q <= 6'h2d;
    end else begin
      if (!run_mode) begin
        held_q <= disable_req;
      end
      noise_q <= {noise_q[4:0], noise_q[5] ^ noise_q[4]};
    end
  end

  // Unused inputs wander, so a wrong input select shows up
  always_comb begin
    digital_in = noise_q;
    digital_in[disable_pin - 3'h1] = held_q;
  end
endmodule
`default_nettype wire
